// >>> verilog/ctcp_timer_pair.sv
// Pair of 8-bit timer/counters with divider, PWM and cascade modes, Wishbone slave
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module ctcp_timer_pair import ctcp_pkg::*; (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [ADR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic SUB_OSC_CLOCK_IN,
    input wire logic [NUM_CH-1:0] EVENT_IN_PIN_IN,
    output logic [NUM_CH-1:0] DIVIDER_OUT_PIN_OUT,
    output logic [NUM_CH-1:0] DUTY_OUT_PIN_OUT,
    output logic [NUM_CH-1:0] CHANNEL_MATCH_IRQ_OUT
);
    ctcp_state_t r;
    ctcp_state_t next_r;

    logic req;
    logic wr;
    logic fs_tick;
    logic slow_tick;
    logic [NUM_CH-1:0] ev_fall;
    logic [NUM_CH-1:0] tick;
    logic [NUM_CH-1:0][7:0] inc;
    logic casc;

    function automatic logic tap_tick(input logic [2:0] sel, input logic [10:0] psc,
                                      input logic slow, input logic fs, input logic ev);
        logic t;
        t = 1'b0;
        case (sel)
            CTCP_CLK_SLOW: t = slow;
            CTCP_CLK_DIV7: t = (psc & MASK_DIV7) == MASK_DIV7;
            CTCP_CLK_DIV5: t = (psc & MASK_DIV5) == MASK_DIV5;
            CTCP_CLK_DIV3: t = (psc & MASK_DIV3) == MASK_DIV3;
            CTCP_CLK_SUB: t = fs;
            CTCP_CLK_DIV1: t = (psc & MASK_DIV1) == MASK_DIV1;
            CTCP_CLK_FULL: t = 1'b1;
            CTCP_CLK_EXT: t = ev;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    assign req = WB_CYC_IN & WB_STB_IN & ~r.ack;
    assign wr = req & WB_WE_IN & WB_SEL_IN[0];
    // Sub clock is sampled; the second and third stages feed the edge detector
    assign fs_tick = r.sub_sync[1] & ~r.sub_sync[2];
    // [R20] Slowest tap swap
    assign slow_tick = r.divsrc ? (fs_tick && r.sub_div == SUB_DIV_LAST)
                                : ((r.psc & MASK_DIV11) == MASK_DIV11);
    assign casc = r.ctrl[1][CTRL_MODE_LSB +: 3] == CTCP_MODE_CASC;

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            // [R19] Falling edge detect
            assign ev_fall[g] = r.ev_sync[g][2] & ~r.ev_sync[g][1];
            assign tick[g] = tap_tick(r.ctrl[g][CTRL_CLK_LSB +: 3], r.psc, slow_tick,
                                      fs_tick, ev_fall[g]);
            assign inc[g] = 8'(r.cnt[g] + CNT_ONE);
        end
    endgenerate

    always_comb begin
        logic [15:0] c16;
        logic run;
        logic [2:0] mode;
        c16 = 16'h0000;
        run = 1'b0;
        mode = 3'h0;
        next_r = r;
        next_r.ack = req;
        next_r.psc = 11'(r.psc + 11'h001);
        next_r.sub_sync = {r.sub_sync[1:0], SUB_OSC_CLOCK_IN};
        if (fs_tick) begin
            next_r.sub_div = 3'(r.sub_div + 3'h1);
        end
        next_r.irq = '0;
        if (req) begin
            next_r.dat = 32'h0000_0000;
        end
        if (req && !WB_WE_IN) begin
            if (WB_ADR_IN == OFS_COUNT) begin
                next_r.dat = {16'h0000, r.cnt[1], r.cnt[0]};
            end
            if (WB_ADR_IN == OFS_CFG) begin
                next_r.dat = {31'h0000_0000, r.divsrc};
            end
        end
        if (wr && WB_ADR_IN == OFS_CFG) begin
            next_r.divsrc = WB_DAT_IN[CFG_DIVSRC_BIT];
        end
        for (int j = 0; j < NUM_CH; j++) begin
            next_r.ev_sync[j] = {r.ev_sync[j][1:0], EVENT_IN_PIN_IN[j]};
            run = r.ctrl[j][CTRL_RUN_BIT];
            mode = r.ctrl[j][CTRL_MODE_LSB +: 3];
            // Both units idle while cascaded; the cascade block below handles the 16-bit count
            if (run && tick[j] && !casc) begin
                case (mode)
                    CTCP_MODE_DIVOUT: begin
                        // [R5] Toggle on match
                        if (inc[j] == r.cmp[j]) begin
                            next_r.cnt[j] = CNT_ZERO;
                            next_r.tff[j] = ~r.tff[j];
                            next_r.irq[j] = 1'b1;
                        end else begin
                            next_r.cnt[j] = inc[j];
                        end
                    end
                    CTCP_MODE_PWM: begin
                        // [R9] [R10] Overflow ends the 256-count period
                        if (r.cnt[j] == CNT_TOP) begin
                            next_r.cnt[j] = CNT_ZERO;
                            next_r.tff[j] = ~r.tff[j];
                            next_r.irq[j] = 1'b1;
                            // [R12] Staged duty moves on period event
                            next_r.duty[j] = r.stage[j];
                        end else begin
                            next_r.cnt[j] = inc[j];
                            if (inc[j] == r.duty[j]) begin
                                next_r.tff[j] = ~r.tff[j];
                            end
                        end
                    end
                    default: begin
                        // [R1] Match clears and interrupts
                        if (inc[j] == r.cmp[j]) begin
                            next_r.cnt[j] = CNT_ZERO;
                            next_r.irq[j] = 1'b1;
                        end else begin
                            next_r.cnt[j] = inc[j];
                        end
                    end
                endcase
            end
            if (req && !WB_WE_IN) begin
                if (WB_ADR_IN == OFS_CTRL[j]) begin
                    next_r.dat = {24'h000000, r.ctrl[j]};
                end
                if (WB_ADR_IN == OFS_CMP[j]) begin
                    next_r.dat = {24'h000000, r.cmp[j]};
                end
                // [R13] Duty reads see the stage
                if (WB_ADR_IN == OFS_DUTY[j]) begin
                    next_r.dat = {24'h000000, r.stage[j]};
                end
            end
            if (wr && WB_ADR_IN == OFS_CTRL[j]) begin
                // [R8] Run and initial-value bits
                next_r.ctrl[j] = WB_DAT_IN[7:0];
                // [R7] Stopping write leaves the flop alone
                if (!run) begin
                    next_r.tff[j] = WB_DAT_IN[CTRL_INIT_BIT];
                end
                if (!WB_DAT_IN[CTRL_RUN_BIT]) begin
                    next_r.cnt[j] = CNT_ZERO;
                end
            end
            // [R3] Compare is unbuffered
            if (wr && WB_ADR_IN == OFS_CMP[j]) begin
                next_r.cmp[j] = WB_DAT_IN[7:0];
            end
            if (wr && WB_ADR_IN == OFS_DUTY[j]) begin
                next_r.stage[j] = WB_DAT_IN[7:0];
                // [R12] Stopped transfer is immediate
                if (!run) begin
                    next_r.duty[j] = WB_DAT_IN[7:0];
                end
            end
        end
        // [R16] Cascaded count on lower unit's clock, gated by upper run bit
        if (casc && r.ctrl[1][CTRL_RUN_BIT] && tick[0]) begin
            c16 = 16'({r.cnt[1], r.cnt[0]} + 16'h0001);
            if (c16 == {r.cmp[1], r.cmp[0]}) begin
                next_r.cnt[1] = CNT_ZERO;
                next_r.cnt[0] = CNT_ZERO;
                next_r.irq[1] = 1'b1;
            end else begin
                next_r.cnt[1] = c16[15:8];
                next_r.cnt[0] = c16[7:0];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            r <= '0;
            r.ctrl <= {CTRL_RST, CTRL_RST};
            r.cmp <= {CMP_RST, CMP_RST};
            r.stage <= {DUTY_RST, DUTY_RST};
            r.duty <= {DUTY_RST, DUTY_RST};
        end else begin
            r <= next_r;
        end
    end

    // [R6] [R11] Pins show the inverted flop; reset clears the flop
    assign DIVIDER_OUT_PIN_OUT = ~r.tff;
    assign DUTY_OUT_PIN_OUT = ~r.tff;
    assign CHANNEL_MATCH_IRQ_OUT = r.irq;
    assign WB_DAT_OUT = r.dat;
    assign WB_ACK_OUT = r.ack;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_run0(ctcp_mode_t m);
        r.ctrl[0][CTRL_RUN_BIT] && r.ctrl[0][CTRL_MODE_LSB +: 3] == m && !casc && !wr;
    endsequence
    sequence s_hit0;
        tick[0] && inc[0] == r.cmp[0];
    endsequence

    a_ack_one_shot: assert property (r.ack |=> !r.ack)
        else $error("ack held longer than one cycle");
    a_ack_on_request: assert property (WB_CYC_IN && WB_STB_IN && !r.ack |=> r.ack)
        else $error("request not acknowledged next cycle");
    a_evt_edge_count: assert property ( // R1
        s_run0(CTCP_MODE_TIMER) and (tick[0] && inc[0] != r.cmp[0])
        |=> r.cnt[0] == 8'($past(r.cnt[0]) + CNT_ONE))
        else $error("counter did not advance on tick");
    a_evt_match_clear: assert property ( // R1
        s_run0(CTCP_MODE_TIMER) and s_hit0 |=> r.cnt[0] == CNT_ZERO && r.irq[0])
        else $error("match did not clear and interrupt");
    a_cmp_immediate: assert property ( // R3
        wr && WB_ADR_IN == OFS_CMP[0] |=> r.cmp[0] == $past(WB_DAT_IN[7:0]))
        else $error("compare write not immediate");
    a_divout_toggle: assert property ( // R5
        s_run0(CTCP_MODE_DIVOUT) and s_hit0
        |=> DIVIDER_OUT_PIN_OUT[0] != $past(DIVIDER_OUT_PIN_OUT[0]) && r.irq[0]
            && r.cnt[0] == CNT_ZERO)
        else $error("divider output did not toggle on match");
    a_stop_hold: assert property ( // R7
        !r.ctrl[0][CTRL_RUN_BIT] && !casc && !wr ##1 !wr |=> $stable(r.tff[0]))
        else $error("output moved while stopped");
    a_init_load: assert property ( // R8
        wr && WB_ADR_IN == OFS_CTRL[0] && !r.ctrl[0][CTRL_RUN_BIT]
        |=> DIVIDER_OUT_PIN_OUT[0] == !$past(WB_DAT_IN[CTRL_INIT_BIT]))
        else $error("initial value not loaded while stopped");
    a_pwm_overflow: assert property ( // R9
        s_run0(CTCP_MODE_PWM) and (tick[0] && r.cnt[0] == CNT_TOP)
        |=> r.cnt[0] == CNT_ZERO && r.irq[0] && r.duty[0] == $past(r.stage[0])
            && DUTY_OUT_PIN_OUT[0] != $past(DUTY_OUT_PIN_OUT[0]))
        else $error("PWM overflow handling wrong");
    a_duty_stopped: assert property ( // R12
        wr && WB_ADR_IN == OFS_DUTY[0] && !r.ctrl[0][CTRL_RUN_BIT]
        |=> r.duty[0] == r.stage[0])
        else $error("stopped duty write not transferred");
    a_duty_readback: assert property ( // R13
        req && !WB_WE_IN && WB_ADR_IN == OFS_DUTY[0]
        |=> WB_ACK_OUT && WB_DAT_OUT[7:0] == $past(r.stage[0]))
        else $error("duty read did not return stage");
    a_casc_match: assert property ( // R16
        casc && r.ctrl[1][CTRL_RUN_BIT] && tick[0] && !wr
        && 16'({r.cnt[1], r.cnt[0]} + 16'h0001) == {r.cmp[1], r.cmp[0]}
        |=> r.irq[1] && r.cnt[1] == CNT_ZERO && r.cnt[0] == CNT_ZERO)
        else $error("cascade match not handled");
endmodule

// >>> verilog/ctcp_pkg.sv
// Constants, register map and state type of the cascadable timer/counter pair
// Contract
// [R1] Event mode counts input falling edges; on compare match interrupt and clear.
// [R2] Event input levels last two machine cycles; rate at most clock over sixteen.
// [R3] Compare writes act at once; software leaves compare alone while running.
// [R4] Software keeps the initial-value bit zero in event and timer modes.
// [R5] Divider mode toggles output flop on match, clears counter, raises interrupt.
// [R6] Divider pin is inverse of output flop; software loads it; reset clears.
// [R7] Stopping holds the output; initial-value changes only in a later write.
// [R8] Control bit 3 runs counter; bit 7 is flop initial value.
// [R9] PWM toggles on duty match; overflow toggles, clears counter, interrupts.
// [R10] PWM period spans the full 8-bit count range of source clock.
// [R11] PWM pin is inverse of output flop; either pulse polarity possible.
// [R12] Running duty writes stage until period interrupt; stopped writes move at once.
// [R13] Duty register reads return the staging register contents.
// [R14] Software writes duty right after the period interrupt, never coinciding.
// [R15] Software stops the counter before entering stop power mode.
// [R16] Cascaded 16-bit timer counts when upper runs; match interrupts upper, clears.
// [R17] Software writes 16-bit compare low byte first, then high byte.
// [R18] Software keeps compare and duty values inside their documented ranges.
// [R19] Event input is synchronised; falling edge found from current and previous sample.
// [R20] Clock field picks prescaler tap; sub-clock tap replaces slowest when selected.
package ctcp_pkg;
    localparam int NUM_CH = 2;
    localparam int ADR_W = 5;

    // Byte offsets on the register bus
    localparam logic [1:0][4:0] OFS_CTRL = {5'h0c, 5'h00};
    localparam logic [1:0][4:0] OFS_CMP = {5'h10, 5'h04};
    localparam logic [1:0][4:0] OFS_DUTY = {5'h14, 5'h08};
    localparam logic [4:0] OFS_COUNT = 5'h18;
    localparam logic [4:0] OFS_CFG = 5'h1c;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_CLK_LSB = 4;
    localparam int CTRL_INIT_BIT = 7;
    localparam int CFG_DIVSRC_BIT = 0;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h80;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [7:0] CNT_TOP = 8'hff;

    // Prescaler tap masks: a tap fires when all masked bits are ones
    localparam logic [10:0] MASK_DIV11 = 11'h7ff;
    localparam logic [10:0] MASK_DIV7 = 11'h07f;
    localparam logic [10:0] MASK_DIV5 = 11'h01f;
    localparam logic [10:0] MASK_DIV3 = 11'h007;
    localparam logic [10:0] MASK_DIV1 = 11'h001;
    localparam logic [2:0] SUB_DIV_LAST = 3'h7;

    typedef enum logic [2:0] {
        CTCP_MODE_TIMER = 3'h0,
        CTCP_MODE_DIVOUT = 3'h1,
        CTCP_MODE_PWM = 3'h2,
        CTCP_MODE_CASC = 3'h4
    } ctcp_mode_t;

    typedef enum logic [2:0] {
        CTCP_CLK_SLOW = 3'h0,
        CTCP_CLK_DIV7 = 3'h1,
        CTCP_CLK_DIV5 = 3'h2,
        CTCP_CLK_DIV3 = 3'h3,
        CTCP_CLK_SUB = 3'h4,
        CTCP_CLK_DIV1 = 3'h5,
        CTCP_CLK_FULL = 3'h6,
        CTCP_CLK_EXT = 3'h7
    } ctcp_clk_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [10:0] psc;
        logic [2:0] sub_sync;
        logic [2:0] sub_div;
        logic divsrc;
        logic [1:0][2:0] ev_sync;
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] cmp;
        logic [1:0][7:0] stage;
        logic [1:0][7:0] duty;
        logic [1:0][7:0] cnt;
        logic [1:0] tff;
        logic [1:0] irq;
    } ctcp_state_t;
endpackage

// >>> verification/ctcp_event_src.sv
// Model of the external event source feeding the event pins
`timescale 1ns/1ps
module ctcp_event_src import ctcp_pkg::*; (
    input wire logic clk_in,
    output logic [NUM_CH-1:0] event_out
);
    // Pins idle high so that the first pulse starts with a falling edge
    initial event_out = '1;

    task automatic pulse(input int ch, input int lo, input int hi);
        @(posedge clk_in);
        event_out[ch] <= 1'b0;
        repeat (lo) @(posedge clk_in);
        event_out[ch] <= 1'b1;
        repeat (hi) @(posedge clk_in);
    endtask
endmodule

// >>> verification/test_cascadable_timer_counter_pair.sv
// Self-checking bench for the timer/counter pair
`timescale 1ns/1ps
module test_cascadable_timer_counter_pair import ctcp_pkg::*;;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sub = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic [NUM_CH-1:0] ev, dpin, wpin, irq;
    int bad_count = 0, total_checks = 0, seed = 34, irqs0 = 0, n, lo, n0;
    logic [31:0] expq[$];
    logic hold;
    int clks[4] = '{6, 5, 3, 4};
    int gaps[4] = '{2, 4, 16, 28};

    always #10 clk = ~clk;
    // Sub oscillator kept far slower than the main clock
    always begin
        repeat (7) @(posedge clk);
        sub <= ~sub;
    end
    // Outputs are sampled mid-cycle, away from the edge that launches them
    always @(negedge clk) if (irq[0] === 1'b1) irqs0++;

    ctcp_timer_pair dut (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .SUB_OSC_CLOCK_IN(sub), .EVENT_IN_PIN_IN(ev),
        .DIVIDER_OUT_PIN_OUT(dpin), .DUTY_OUT_PIN_OUT(wpin), .CHANNEL_MATCH_IRQ_OUT(irq));
    ctcp_event_src src (.clk_in(clk), .event_out(ev));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data is judged in the cycle where ack stands high
    always @(negedge clk) if (ack === 1'b1 && we === 1'b0) begin
        if (expq.size() == 0) check(rdat, 32'hdead_beef);
        else check(rdat, expq.pop_front());
    end

    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        sel <= 4'h1;
        do @(negedge clk); while (ack !== 1'b1);
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        wb(1'b0, a, 8'h00);
    endtask

    // Cycles between two interrupts of a channel, and how many had the duty pin low
    task automatic period(input int ch, output int all, output int low);
        do @(negedge clk); while (irq[ch] !== 1'b1);
        all = 0;
        low = 0;
        do begin
            @(negedge clk);
            all++;
            if (wpin[ch] === 1'b0) low++;
        end while (irq[ch] !== 1'b1);
    endtask

    task automatic gap(input int ch, output int cnt);
        logic v;
        v = dpin[ch];
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (dpin[ch] === v);
    endtask

    function automatic int rnd_w();
        int r;
        r = $random(seed);
        return 2 + (r & 3);
    endfunction

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        check({30'h0, dpin}, 32'h3);
        rd(OFS_CTRL[0], {24'h0, CTRL_RST});
        rd(OFS_CMP[1], {24'h0, CMP_RST});
        rd(OFS_DUTY[0], {24'h0, DUTY_RST});
        rd(OFS_COUNT, 32'h0);
        rd(OFS_CFG, 32'h0);
        rd(5'h02, 32'h0);
        wr(OFS_CFG, 8'h01);
        rd(OFS_CFG, 32'h1);
        wr(OFS_CFG, 8'h00);
        // Event counting on channel 0 with random pulse widths
        // Initial-value bit stays zero, compare in range
        wr(OFS_CMP[0], 8'h03);
        wr(OFS_CTRL[0], 8'h78);
        repeat (2) src.pulse(0, rnd_w(), rnd_w());
        repeat (4) @(posedge clk);
        rd(OFS_COUNT, 32'h2);
        n0 = irqs0;
        src.pulse(0, rnd_w(), rnd_w() + 4);
        check(32'(irqs0 - n0), 32'h1);
        rd(OFS_COUNT, 32'h0);
        wr(OFS_CTRL[0], 8'h70);
        // Divider on channel 1 over several clock taps
        wr(OFS_CMP[1], 8'h02);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL[1], {1'b0, 3'(clks[i]), 4'h9});
            gap(1, n);
            gap(1, n);
            check(32'(n), 32'(gaps[i]));
            wr(OFS_CTRL[1], {1'b0, 3'(clks[i]), 4'h1});
        end
        hold = dpin[1];
        repeat (20) @(posedge clk);
        check({31'h0, dpin[1]}, {31'h0, hold});
        wr(OFS_CTRL[1], 8'h81);
        check({30'h0, dpin[1], wpin[1]}, 32'h0);
        wr(OFS_CTRL[1], 8'h01);
        check({31'h0, dpin[1]}, 32'h1);
        // PWM on channel 0, duty staged while running
        wr(OFS_DUTY[0], 8'h40);
        wr(OFS_CTRL[0], 8'h6a);
        period(0, n, lo);
        check(32'(n), 32'd256);
        check(32'(lo), 32'd192);
        // New duty written right after the period interrupt
        wr(OFS_DUTY[0], 8'h10);
        rd(OFS_DUTY[0], 32'h10);
        period(0, n, lo);
        check(32'(lo), 32'd240);
        wr(OFS_CTRL[0], 8'h62);
        // Cascaded 16-bit timer, compare low byte first
        wr(OFS_CTRL[0], 8'h60);
        // Low compare byte first, then high
        wr(OFS_CMP[0], 8'h05);
        wr(OFS_CMP[1], 8'h01);
        wr(OFS_CTRL[1], 8'h0c);
        n0 = irqs0;
        period(1, n, lo);
        check(32'(n), 32'd261);
        check(32'(irqs0 - n0), 32'h0);
        wr(OFS_CTRL[1], 8'h04);
        tally_and_finish();
    end
endmodule
